/* File: verilog/hv_io_regs.svh */
// Register offsets, field positions, reset values and encodings.
`ifndef HV_IO_REGS_SVH
`define HV_IO_REGS_SVH

// ==========================================================================
// Register numbers on the local control interface
`define HV_PIN_CONFIG_ADDR      8'h40
`define BUCK_REG_CONFIG_ADDR    8'h41
`define OUT_GATE_OVERRIDE_ADDR  8'h42

// ==========================================================================
// Field positions of hv_pin_config
`define SLOW_SLEW_LSB           0
`define REDUCED_HIGH_LSB        8
`define REDUCED_LOW_LSB         16
`define DIFF_PAIR_LSB           24

// ==========================================================================
// Field positions of buck_regulator_config
`define FIXED_FREQ_LSB          0
`define FIXED_GAIN_LSB          2
`define FIXED_DAMP_LSB          4
`define FIXED_OCP_OFF_BIT       6
`define ADJ_FREQ_LSB            8
`define ADJ_GAIN_LSB            10
`define ADJ_DAMP_LSB            12
`define ADJ_OCP_OFF_BIT         14
`define ADJ_OFF_BIT             15

// ==========================================================================
// Field position of output_gating_override
`define OVERRIDE_BIT            0

// ==========================================================================
// Reset values
`define HV_PIN_CONFIG_RST       32'h0000_0000
`define BUCK_REG_CONFIG_RST     16'h0000
`define OVERRIDE_RST            1'b0

// ==========================================================================
// Application-layer state codes on the slave state machine port
`define AL_SAFE_OP              4'h4
`define AL_OPERATIONAL          4'h8

`endif

/* File: verilog/hv_io_pkg.sv */
// Types shared by the configuration and gating block.
package hv_io_pkg;

  // Switching frequency code, nominal values.
  typedef enum logic [1:0] {
    FREQ_250K = 2'h0,
    FREQ_125K = 2'h1,
    FREQ_500K = 2'h2,
    FREQ_1M   = 2'h3
  } switch_freq_t;

  // Loop gain or damping scale code.
  typedef enum logic [1:0] {
    SCALE_100 = 2'h0,
    SCALE_150 = 2'h1,
    SCALE_200 = 2'h2,
    SCALE_50  = 2'h3
  } loop_scale_t;

  // Settings for one buck regulator.
  typedef struct packed {
    switch_freq_t freq;
    loop_scale_t  gain;
    loop_scale_t  damping;
    logic         ocp_off;
  } reg_cfg_t;

  // Settings for the eight high-voltage pins.
  typedef struct packed {
    logic [3:0] diff_pair_enable;
    logic [7:0] reduced_low_drive;
    logic [7:0] reduced_high_drive;
    logic [7:0] slow_slew_select;
  } hv_cfg_t;

  // Load sequence of the block.
  typedef enum logic [2:0] {
    ST_PRELOAD = 3'b001,
    ST_RUN     = 3'b010,
    ST_IDLE    = 3'b100
  } load_state_t;

  // State of the block, apart from the port synchroniser stages.
  typedef struct packed {
    load_state_t st;
    logic [31:0] hv_pin_config;
    logic [15:0] buck_config;
    logic        override;
    logic [23:0] out_val;
    logic [23:0] out_en;
    logic [23:0] fb_in;
    logic [23:0] local_in;
  } state_t;

endpackage : hv_io_pkg

/* File: verilog/hv_io_cfg.sv */
// Pin and regulator configuration with output gating by layer state.
`timescale 1ns/1ps
`default_nettype none
`include "hv_io_regs.svh"

module hv_io_cfg (
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RST,
  // Local control register writes
  input  wire logic                  WR_EN,
  input  wire logic [7:0]            WR_ADDR,
  input  wire logic [31:0]           WR_DATA,
  // Startup preload from configuration memory
  input  wire logic                  PRELOAD_VALID,
  input  wire logic                  PRELOAD_DONE,
  input  wire logic [31:0]           PRELOAD_HV,
  input  wire logic [15:0]           PRELOAD_BUCK,
  // Slave state and port data
  input  wire logic [3:0]            AL_STATE,
  input  wire logic [23:0]           MASTER_OWNS,
  input  wire logic [23:0]           MASTER_OUT,
  input  wire logic [23:0]           LOCAL_OUT,
  input  wire logic [23:0]           PORT_IN,
  // Configuration outputs
  output var hv_io_pkg::hv_cfg_t     HV_CFG,
  output var hv_io_pkg::reg_cfg_t    FIXED_REG_CFG,
  output var hv_io_pkg::reg_cfg_t    ADJ_REG_CFG,
  output var logic                   ADJ_REG_OFF,
  output var logic                   OVERRIDE,
  // Gated ports
  output var logic [23:0]            OUT_VALUE,
  output var logic [23:0]            OUT_ENABLE,
  output var logic [23:0]            MASTER_IN,
  output var logic [23:0]            LOCAL_IN,
  output var logic                   CFG_READY
);

  // ========================================================================
  // State
  hv_io_pkg::state_t s;
  hv_io_pkg::state_t next_s;

  // Port synchroniser stages; the first stage feeds only the second.
  logic [23:0] in_m1;
  logic [23:0] in_m2;
  logic [23:0] in_m3;
  // Filtered inputs: a bit moves only when stages two and three agree.
  logic [23:0] in_filt;

  // Regulator fields sit LSB-first in the register but MSB-first in the
  // struct, so each field is moved by its own bit slice rather than by one plain slice.
  function automatic hv_io_pkg::reg_cfg_t unpack_reg(input logic [6:0] f);
    unpack_reg = {f[1:0], f[3:2], f[5:4], f[6]};
  endfunction : unpack_reg

  // True when the layer state permits master output control.
  function automatic logic is_op(input logic [3:0] st);
    is_op = (st == `AL_OPERATIONAL);
  endfunction : is_op

  wire logic out_open = s.override || is_op(AL_STATE);
  wire logic in_open = is_op(AL_STATE) || (AL_STATE == `AL_SAFE_OP);

  // ========================================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    // A bit that the two late stages disagree on keeps its old value.
    for (int i = 0; i < 24; i++) begin
      in_filt[i] = (in_m2[i] == in_m3[i]) ? in_m3[i] : s.local_in[i];
    end
    case (s.st)
      hv_io_pkg::ST_PRELOAD: begin
        // Preload words land before the host may write anything.
        if (PRELOAD_VALID) begin
          next_s.hv_pin_config = PRELOAD_HV;
          next_s.buck_config   = PRELOAD_BUCK;
        end
        if (PRELOAD_DONE) begin
          next_s.st = hv_io_pkg::ST_RUN;
        end
      end
      hv_io_pkg::ST_RUN: begin
        // Only the local port reaches these; no master write path exists.
        if (WR_EN) begin
          case (WR_ADDR)
            `HV_PIN_CONFIG_ADDR: begin
              next_s.hv_pin_config = {4'h0, WR_DATA[27:0]};
            end
            `BUCK_REG_CONFIG_ADDR: begin
              next_s.buck_config = WR_DATA[15:0];
            end
            `OUT_GATE_OVERRIDE_ADDR: begin
              next_s.override = WR_DATA[`OVERRIDE_BIT];
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_s.st = hv_io_pkg::ST_PRELOAD;
      end
    endcase
    // Outputs: owned bits follow the master only when open; the override
    // hands every bit to the local side.
    for (int i = 0; i < 24; i++) begin
      if (s.override) begin
        next_s.out_val[i] = LOCAL_OUT[i];
        next_s.out_en[i]  = 1'b1;
      end else if (MASTER_OWNS[i]) begin
        next_s.out_val[i] = MASTER_OUT[i];
        next_s.out_en[i]  = out_open;
      end else begin
        next_s.out_val[i] = LOCAL_OUT[i];
        next_s.out_en[i]  = out_open;
      end
    end
    // Inputs are never gated by the override.
    next_s.local_in = in_filt;
    next_s.fb_in    = in_open ? (in_filt & MASTER_OWNS) : 24'h000000;
  end

  // ========================================================================
  // Registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      s.st            <= hv_io_pkg::ST_PRELOAD;
      s.hv_pin_config <= `HV_PIN_CONFIG_RST;
      s.buck_config   <= `BUCK_REG_CONFIG_RST;
      s.override      <= `OVERRIDE_RST;
      s.out_val       <= 24'h000000;
      s.out_en        <= 24'h000000;
      s.fb_in         <= 24'h000000;
      s.local_in      <= 24'h000000;
      in_m1           <= 24'h000000;
      in_m2           <= 24'h000000;
      in_m3           <= 24'h000000;
    end else begin
      s     <= next_s;
      in_m1 <= PORT_IN;
      in_m2 <= in_m1;
      in_m3 <= in_m2;
    end
  end

  // ========================================================================
  // Outputs straight from state flip-flops
  always_comb begin
    HV_CFG                = s.hv_pin_config[27:0];
    FIXED_REG_CFG         = unpack_reg(s.buck_config[6:0]);
    ADJ_REG_CFG           = unpack_reg(s.buck_config[14:8]);
    ADJ_REG_OFF           = s.buck_config[`ADJ_OFF_BIT];
    OVERRIDE              = s.override;
    OUT_VALUE             = s.out_val;
    OUT_ENABLE            = s.out_en;
    MASTER_IN             = s.fb_in;
    LOCAL_IN              = s.local_in;
    CFG_READY             = s.st == hv_io_pkg::ST_RUN;
  end

  // ========================================================================
  // Checks
  property p_gate_closed;
    @(posedge MCLK) disable iff (RST)
      (!s.override && !is_op(AL_STATE)) |=> (OUT_ENABLE == 24'h000000);
  endproperty
  a_gate_closed: assert property (p_gate_closed)
    else $error("Outputs enabled outside operational state.");

  property p_override_open;
    @(posedge MCLK) disable iff (RST)
      s.override |=> (OUT_ENABLE == 24'hFFFFFF && OUT_VALUE == $past(LOCAL_OUT));
  endproperty
  a_override_open: assert property (p_override_open)
    else $error("Override did not give local control.");

  property p_master_in;
    @(posedge MCLK) disable iff (RST)
      !in_open |=> (MASTER_IN == 24'h000000);
  endproperty
  a_master_in: assert property (p_master_in)
    else $error("Master read inputs in a closed state.");

  property p_ovr_write;
    @(posedge MCLK) disable iff (RST)
      (CFG_READY && WR_EN && WR_ADDR == `OUT_GATE_OVERRIDE_ADDR)
        |=> (OVERRIDE == $past(WR_DATA[0]));
  endproperty
  a_ovr_write: assert property (p_ovr_write)
    else $error("Override write not taken.");

  property p_hv_write;
    @(posedge MCLK) disable iff (RST)
      (CFG_READY && WR_EN && WR_ADDR == `HV_PIN_CONFIG_ADDR)
        |=> (HV_CFG == $past(WR_DATA[27:0]));
  endproperty
  a_hv_write: assert property (p_hv_write)
    else $error("Pin configuration write not taken.");

  property p_buck_write;
    @(posedge MCLK) disable iff (RST)
      (CFG_READY && WR_EN && WR_ADDR == `BUCK_REG_CONFIG_ADDR)
        |=> (ADJ_REG_OFF == $past(WR_DATA[15]));
  endproperty
  a_buck_write: assert property (p_buck_write)
    else $error("Regulator configuration write not taken.");

  property p_preload;
    @(posedge MCLK) disable iff (RST)
      (!CFG_READY && PRELOAD_VALID)
        |=> (ADJ_REG_CFG == unpack_reg($past(PRELOAD_BUCK[14:8])));
  endproperty
  a_preload: assert property (p_preload)
    else $error("Preload did not load the regulator settings.");

  property p_no_early_write;
    @(posedge MCLK) disable iff (RST)
      (!CFG_READY && !PRELOAD_VALID) |=> $stable(HV_CFG);
  endproperty
  a_no_early_write: assert property (p_no_early_write)
    else $error("Pin configuration changed during preload.");

endmodule : hv_io_cfg
`default_nettype wire

/* File: dv/ctrl_host_model.sv */
// Behavioural host on the local control interface: preload and writes.
`timescale 1ns/1ps
`default_nettype none

module ctrl_host_model (
  // Clock
  input  wire logic        MCLK,
  // Register writes
  output var  logic        WR_EN,
  output var  logic [7:0]  WR_ADDR,
  output var  logic [31:0] WR_DATA,
  // Startup preload
  output var  logic        PRELOAD_VALID,
  output var  logic        PRELOAD_DONE,
  output var  logic [31:0] PRELOAD_HV,
  output var  logic [15:0] PRELOAD_BUCK
);
  // ==========================================================================
  // Idle values at time zero.
  initial begin
    WR_EN = 1'b0;
    WR_ADDR = 8'h00;
    WR_DATA = 32'h0000_0000;
    PRELOAD_VALID = 1'b0;
    PRELOAD_DONE = 1'b0;
    PRELOAD_HV = 32'h0000_0000;
    PRELOAD_BUCK = 16'h0000;
  end

  // One write; back-to-back calls keep the strobe high between writes.
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    #1;
    WR_EN = 1'b1;
    WR_ADDR = a;
    WR_DATA = d;
  endtask : write

  // Drops the strobe; data is inverted so a stale word never looks valid.
  task automatic release_bus();
    @(posedge MCLK);
    #1;
    WR_EN = 1'b0;
    WR_DATA = ~WR_DATA;
  endtask : release_bus

  // One preload word, with the end of the preload phase in the same cycle.
  task automatic preload(input logic [31:0] hv, input logic [15:0] bk);
    @(posedge MCLK);
    #1;
    PRELOAD_VALID = 1'b1;
    PRELOAD_DONE = 1'b1;
    PRELOAD_HV = hv;
    PRELOAD_BUCK = bk;
    @(posedge MCLK);
    #1;
    PRELOAD_VALID = 1'b0;
    PRELOAD_DONE = 1'b0;
    PRELOAD_HV = ~hv;
    PRELOAD_BUCK = ~bk;
  endtask : preload
endmodule : ctrl_host_model
`default_nettype wire

/* File: dv/hv_io_regulator_cfg_and_output_gating_tb.sv */
// Self-checking bench for the configuration and output gating block.
`timescale 1ns/1ps
`default_nettype none
`include "hv_io_regs.svh"

module hv_io_regulator_cfg_and_output_gating_tb;
  // ==========================================================================
  // Signals, shadow registers and note queues
  typedef struct { int due; logic [44:0] v; } cfg_note_t;
  typedef struct { int due; logic [95:0] v; } gate_note_t;
  logic                mclk = 1'b0;
  logic                rst = 1'b1;
  logic                wr_en, pl_valid, pl_done, cfg_ready, adj_off, ovr;
  logic [7:0]          wr_addr;
  logic [31:0]         wr_data, pl_hv, hv_sh = 32'h0, d;
  logic [15:0]         pl_buck, bk_sh = 16'h0;
  logic [3:0]          al_state = 4'h0;
  logic [23:0]         owns, m_out, l_out, port_in;
  logic [23:0]         out_value, out_enable, master_in, local_in;
  logic                ovr_sh = 1'b0, rdy_sh = 1'b0;
  hv_io_pkg::hv_cfg_t  hv_cfg;
  hv_io_pkg::reg_cfg_t fixed_cfg, adj_cfg;
  logic [3:0]          al_tab [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
  int                  cyc = 0, fail_count = 0, checked = 0, seed;
  cfg_note_t           cq[$];
  gate_note_t          gq[$];

  // Clock and cycle count; the count dates every note.
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  ctrl_host_model host (.MCLK(mclk), .WR_EN(wr_en), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .PRELOAD_VALID(pl_valid), .PRELOAD_DONE(pl_done),
    .PRELOAD_HV(pl_hv), .PRELOAD_BUCK(pl_buck));

  hv_io_cfg dut (.MCLK(mclk), .RST(rst), .WR_EN(wr_en), .WR_ADDR(wr_addr),
    .WR_DATA(wr_data), .PRELOAD_VALID(pl_valid), .PRELOAD_DONE(pl_done),
    .PRELOAD_HV(pl_hv), .PRELOAD_BUCK(pl_buck), .AL_STATE(al_state),
    .MASTER_OWNS(owns), .MASTER_OUT(m_out), .LOCAL_OUT(l_out),
    .PORT_IN(port_in), .HV_CFG(hv_cfg), .FIXED_REG_CFG(fixed_cfg),
    .ADJ_REG_CFG(adj_cfg), .ADJ_REG_OFF(adj_off), .OVERRIDE(ovr),
    .OUT_VALUE(out_value), .OUT_ENABLE(out_enable), .MASTER_IN(master_in),
    .LOCAL_IN(local_in), .CFG_READY(cfg_ready));

  // ==========================================================================
  // Expectations, kept from the shadow registers and the bench's own inputs
  task automatic note_cfg(input int lag);
    cq.push_back('{cyc + lag, {rdy_sh, hv_sh[27:0],
                               bk_sh[1:0], bk_sh[3:2], bk_sh[5:4], bk_sh[6],
                               bk_sh[9:8], bk_sh[11:10], bk_sh[13:12],
                               bk_sh[14], bk_sh[15], ovr_sh}});
  endtask : note_cfg

  task automatic note_gate();
    logic [23:0] en, v, mi;
    en = (ovr_sh || al_state == `AL_OPERATIONAL) ? 24'hFFFFFF : 24'h0;
    v = ovr_sh ? l_out : (owns & m_out) | (~owns & l_out);
    mi = (al_state == `AL_SAFE_OP || al_state == `AL_OPERATIONAL) ?
         (port_in & owns) : 24'h0;
    gq.push_back('{cyc, {v & en, en, mi, port_in}});
  endtask : note_gate

  // Bits 31:28 and override bits 31:1 are dropped, so unused here.
  task automatic shadow(input logic [7:0] a, input logic [31:0] w);
    if (a == `HV_PIN_CONFIG_ADDR) hv_sh = w;
    if (a == `BUCK_REG_CONFIG_ADDR) bk_sh = w[15:0];
    if (a == `OUT_GATE_OVERRIDE_ADDR) ovr_sh = w[0];
  endtask : shadow

  task automatic cmp_cfg(input logic [44:0] e, input logic [44:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error config exp %h seen %h", e, g);
    end
  endtask : cmp_cfg

  task automatic cmp_gate(input logic [95:0] e, input logic [95:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error ports exp %h seen %h", e, g);
    end
  endtask : cmp_gate

  // Watcher: takes the oldest note when its cycle comes round.
  always @(negedge mclk) begin
    if (cq.size() > 0 && cq[0].due == cyc) begin
      cmp_cfg(cq[0].v, {cfg_ready, hv_cfg, fixed_cfg, adj_cfg, adj_off,
                        ovr});
      cq.delete(0);
    end
    if (gq.size() > 0 && gq[0].due == cyc) begin
      cmp_gate(gq[0].v, {out_value & out_enable, out_enable, master_in,
                         local_in});
      gq.delete(0);
    end
  end

  // Single place where the run ends; notes never seen count as errors.
  task automatic end_of_test();
    fail_count += cq.size() + gq.size();
    $display("Checks %0d, errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  // Guards against a hang anywhere in the sequence.
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = $urandom(32'h727B3194);
    {owns, m_out, l_out, port_in} = {$urandom, $urandom, $urandom};
    repeat (3) @(posedge mclk);
    #1;
    note_cfg(0);
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    // A write before the preload ends is ignored.
    host.write(`HV_PIN_CONFIG_ADDR, $urandom);
    host.release_bus();
    note_cfg(0);
    d = $urandom;
    host.preload(d, d[31:16]);
    {hv_sh, bk_sh, rdy_sh} = {d, d[31:16], 1'b1};
    note_cfg(0);
    // A late preload must leave the settings alone.
    host.preload(~d, d[15:0]);
    note_cfg(0);
    // Back-to-back writes to mapped and unmapped numbers.
    for (int i = 0; i < 24; i++) begin
      d = $urandom;
      host.write(8'h40 + 8'($urandom_range(3)), d);
      shadow(wr_addr, d);
      note_cfg(1);
    end
    // Every code in every two-bit regulator field.
    for (int k = 0; k < 4; k++) begin
      host.write(`BUCK_REG_CONFIG_ADDR, 32'(k * 16'h5555));
      shadow(wr_addr, wr_data);
      note_cfg(1);
    end
    host.release_bus();
    // Output and input gating in each layer state, with and without override.
    foreach (al_tab[j]) begin
      for (int o = 0; o < 2; o++) begin
        d = ($urandom & 32'hFE) | 32'(o);
        host.write(`OUT_GATE_OVERRIDE_ADDR, d);
        shadow(wr_addr, d);
        host.release_bus();
        al_state = al_tab[j];
        {owns, m_out, l_out, port_in} = {$urandom, $urandom, $urandom};
        repeat (7) @(posedge mclk);
        #1;
        note_gate();
      end
    end
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule : hv_io_regulator_cfg_and_output_gating_tb
`default_nettype wire
